/* hw/cdm_pkg.sv */
// Purpose: Shared constants and types for the core data memory map.
// Assumes: Single clock, synchronous active-high reset.
// Notes: Addresses are internal data and special-register addresses.
`default_nettype none
package cdm_pkg;
  localparam logic [7:0] CDM_BANK_BASE = 8'h00;
  localparam logic [7:0] CDM_BANK_LAST = 8'h1f;
  localparam logic [7:0] CDM_BIT_BASE = 8'h20;
  localparam logic [7:0] CDM_BIT_LAST = 8'h2f;
  localparam logic [7:0] CDM_UPPER_BASE = 8'h80;
  localparam logic [7:0] CDM_ADDR_STACK_POINTER = 8'h81;
  localparam logic [7:0] CDM_ADDR_DATA_POINTER_LOW = 8'h82;
  localparam logic [7:0] CDM_ADDR_DATA_POINTER_HIGH = 8'h83;
  localparam logic [7:0] CDM_ADDR_PROGRAM_STATUS_WORD = 8'hd0;
  localparam logic [7:0] CDM_ADDR_ACCUMULATOR = 8'he0;
  localparam logic [7:0] CDM_ADDR_MULTIPLY_AUX = 8'hf0;
  localparam logic [7:0] CDM_RST_STACK_POINTER = 8'h07;
  localparam logic [7:0] CDM_RST_OTHER = 8'h00;
  localparam int CDM_POS_BANK_SELECT_LOW = 3;
  localparam int CDM_POS_BANK_SELECT_HIGH = 4;
  localparam logic [2:0] CDM_SFR_BIT_NIBBLE_MASK = 3'h7;
  localparam int CDM_RAM_DEPTH = 256;

  typedef enum logic [2:0] {
    CDM_OP_NONE,
    CDM_OP_READ,
    CDM_OP_WRITE,
    CDM_OP_PUSH,
    CDM_OP_POP
  } cdm_op_e;

  typedef enum logic [1:0] {
    CDM_MODE_DIRECT,
    CDM_MODE_INDIRECT,
    CDM_MODE_WORKING
  } cdm_mode_e;

  typedef enum {
    CDM_ST_IDLE,
    CDM_ST_PTR,
    CDM_ST_DONE
  } cdm_state_e;
endpackage : cdm_pkg
`default_nettype wire

/* hw/cdm_ram_if.sv */
// Purpose: Carries one access between the map logic and the data RAM.
// Assumes: One access per cycle, read data valid the next cycle.
// Notes: Full 256-byte index; upper half reached only indirectly or through the stack.
`default_nettype none
interface cdm_ram_if;
  logic [7:0] addr;
  logic write;
  logic [7:0] wdata;
  logic [7:0] wmask;
  logic [7:0] rdata;
  modport master (output addr, output write, output wdata, output wmask, input rdata);
  modport slave (input addr, input write, input wdata, input wmask, output rdata);
endinterface : cdm_ram_if
`default_nettype wire

/* hw/cdm_ram.sv */
// Purpose: 256-byte internal data RAM with per-bit write mask.
// Assumes: Synchronous write, registered read.
// Notes: Mask lets single-bit writes leave neighbours intact.
`default_nettype none
module cdm_ram
  import cdm_pkg::*;
(
  input wire logic sys_clk,
  cdm_ram_if.slave ram
);
  logic [7:0] mem [CDM_RAM_DEPTH];
  logic [7:0] rdata_q;

  always_ff @(posedge sys_clk) begin
    if (ram.write) begin
      mem[ram.addr] <= (mem[ram.addr] & ~ram.wmask) | (ram.wdata & ram.wmask);
    end
    rdata_q <= mem[ram.addr];
  end

  assign ram.rdata = rdata_q;
endmodule : cdm_ram
`default_nettype wire

/* hw/cdm_core_map.sv */
// Contract
// - Bytes 0x00..0x1F form four banks of eight working registers.
// - One bank active; status bits 3 and 4 select it.
// - Indirect pointer comes only from working register zero or one.
// - Bytes 0x20..0x2F reachable as bytes and as 128 bits.
// - Low bit address is eight times byte offset plus bit position.
// - Bit or byte access chosen by the operand kind.
// - Push writes at pointer plus one, then pointer increments.
// - Stack pointer holds the newest occupied location.
// - Reset loads stack pointer with 0x07.
// - Stack may sit anywhere in the 256-byte memory.
// - Stack pointer is special register 0x81.
// - Direct accesses at 0x80..0xFF go to special registers.
// - Special registers ending 0x0 or 0x8 accept bit access.
// - Other special registers accept byte access only.
// - Indirect accesses above 0x7F reach upper 128-byte RAM.
//
// Purpose: Data memory map of an 8-bit core: banks, bit area, stack, special registers.
// Assumes: Execution unit holds req for one cycle and waits for done.
// Notes: Peripheral special registers are served outside via the ext port.
`default_nettype none
module cdm_core_map
  import cdm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic req,
  input wire cdm_op_e op,
  input wire cdm_mode_e mode,
  input wire logic is_bit,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wbit,
  output logic done,
  output logic [7:0] rdata,
  output logic rbit,
  output logic bad_bit,
  output logic [7:0] stack_pointer,
  output logic [1:0] active_bank,
  output logic ext_req,
  output logic ext_write,
  output logic [7:0] ext_addr,
  output logic [7:0] ext_wdata,
  input wire logic [7:0] ext_rdata
);
  // ---------------------------------------------
  // Storage
  // ---------------------------------------------
  cdm_ram_if ram ();
  cdm_ram u_ram (.sys_clk(sys_clk), .ram(ram));

  cdm_state_e state, next_state;
  logic [7:0] next_stack_pointer;
  logic [7:0] data_pointer_low, next_data_pointer_low;
  logic [7:0] data_pointer_high, next_data_pointer_high;
  logic [7:0] program_status_word, next_program_status_word;
  logic [7:0] accumulator, next_accumulator;
  logic [7:0] multiply_aux_register, next_multiply_aux_register;
  logic [7:0] next_rdata;
  logic next_rbit, next_done, next_bad_bit;
  logic next_ext_req, next_ext_write;
  logic [7:0] next_ext_addr, next_ext_wdata;
  // Latched request, so a second ram cycle can use the pointer
  cdm_op_e op_q, next_op_q;
  logic bit_q, next_bit_q, wbit_q, next_wbit_q, sfr_q, next_sfr_q;
  logic [7:0] byte_q, next_byte_q, wdata_q, next_wdata_q;
  logic [2:0] pos_q, next_pos_q;

  // ---------------------------------------------
  // Decode helpers
  // ---------------------------------------------
  // bank select bits
  assign active_bank = {program_status_word[CDM_POS_BANK_SELECT_HIGH],
                        program_status_word[CDM_POS_BANK_SELECT_LOW]};

  function automatic logic [7:0] work_addr(input logic [1:0] bank, input logic [2:0] idx);
    work_addr = {3'h0, bank, idx};
  endfunction : work_addr

  // Byte/position of a bit address; low half is the bit area
  function automatic logic [7:0] bit_byte(input logic [7:0] ba);
    if (ba[7]) begin
      bit_byte = {ba[7:3], 3'h0};
    end else begin
      // eight bits per byte from 0x20
      bit_byte = CDM_BIT_BASE + {4'h0, ba[6:3]};
    end
  endfunction : bit_byte

  function automatic logic sfr_hit(input logic [7:0] a);
    sfr_hit = (a == CDM_ADDR_STACK_POINTER) || (a == CDM_ADDR_DATA_POINTER_LOW) ||
              (a == CDM_ADDR_DATA_POINTER_HIGH) || (a == CDM_ADDR_PROGRAM_STATUS_WORD) ||
              (a == CDM_ADDR_ACCUMULATOR) || (a == CDM_ADDR_MULTIPLY_AUX);
  endfunction : sfr_hit

  logic [7:0] sfr_rd;
  always_comb begin
    sfr_rd = ext_rdata;
    if (byte_q == CDM_ADDR_STACK_POINTER) begin
      sfr_rd = stack_pointer;
    end else if (byte_q == CDM_ADDR_DATA_POINTER_LOW) begin
      sfr_rd = data_pointer_low;
    end else if (byte_q == CDM_ADDR_DATA_POINTER_HIGH) begin
      sfr_rd = data_pointer_high;
    end else if (byte_q == CDM_ADDR_PROGRAM_STATUS_WORD) begin
      sfr_rd = program_status_word;
    end else if (byte_q == CDM_ADDR_ACCUMULATOR) begin
      sfr_rd = accumulator;
    end else if (byte_q == CDM_ADDR_MULTIPLY_AUX) begin
      sfr_rd = multiply_aux_register;
    end
  end

  // Merge a single bit into a byte for a bit write
  logic [7:0] merged;
  always_comb begin
    merged = sfr_rd;
    merged[pos_q] = wbit_q;
  end

  // ---------------------------------------------
  // Sequencer
  // ---------------------------------------------
  always_comb begin
    next_state = state;
    next_stack_pointer = stack_pointer;
    next_data_pointer_low = data_pointer_low;
    next_data_pointer_high = data_pointer_high;
    next_program_status_word = program_status_word;
    next_accumulator = accumulator;
    next_multiply_aux_register = multiply_aux_register;
    next_rdata = rdata;
    next_rbit = rbit;
    next_done = 1'b0;
    next_bad_bit = 1'b0;
    next_ext_req = 1'b0;
    next_ext_write = 1'b0;
    next_ext_addr = ext_addr;
    next_ext_wdata = ext_wdata;
    next_op_q = op_q;
    next_bit_q = bit_q;
    next_wbit_q = wbit_q;
    next_sfr_q = sfr_q;
    next_byte_q = byte_q;
    next_wdata_q = wdata_q;
    next_pos_q = pos_q;
    ram.addr = addr;
    ram.write = 1'b0;
    ram.wdata = wdata;
    ram.wmask = 8'hff;
    case (state)
      CDM_ST_IDLE: begin
        if (req && op != CDM_OP_NONE) begin
          next_op_q = op;
          next_wdata_q = wdata;
          next_wbit_q = wbit;
          next_pos_q = addr[2:0];
          next_bit_q = 1'b0;
          next_sfr_q = 1'b0;
          next_byte_q = addr;
          next_state = CDM_ST_DONE;
          if (op == CDM_OP_PUSH) begin
            ram.addr = stack_pointer + 8'h01;
            ram.write = 1'b1;
            next_stack_pointer = stack_pointer + 8'h01;
          end else if (op == CDM_OP_POP) begin
            ram.addr = stack_pointer;
            next_stack_pointer = stack_pointer - 8'h01;
          end else if (mode == CDM_MODE_INDIRECT) begin
            // pointer from working reg zero or one
            ram.addr = work_addr(active_bank, {2'h0, addr[0]});
            next_state = CDM_ST_PTR;
          end else if (mode == CDM_MODE_WORKING) begin
            ram.addr = work_addr(active_bank, addr[2:0]);
            ram.write = (op == CDM_OP_WRITE);
          end else if (is_bit) begin
            next_bit_q = 1'b1;
            next_byte_q = bit_byte(addr);
            next_sfr_q = addr[7];
            ram.addr = bit_byte(addr);
            ram.wdata = {8{wbit}};
            ram.wmask = 8'h01 << addr[2:0];
            ram.write = (op == CDM_OP_WRITE) && !addr[7];
            if (addr[7]) begin
              next_ext_req = !sfr_hit(bit_byte(addr));
              next_ext_addr = bit_byte(addr);
            end
          end else if (addr[7]) begin
            // direct upper half is special registers
            next_sfr_q = 1'b1;
            next_ext_req = !sfr_hit(addr) && (op == CDM_OP_READ);
            next_ext_addr = addr;
          end else begin
            ram.write = (op == CDM_OP_WRITE);
          end
        end
      end
      CDM_ST_PTR: begin
        // indirect upper addresses go to RAM
        ram.addr = ram.rdata;
        ram.wdata = wdata_q;
        ram.write = (op_q == CDM_OP_WRITE);
        next_state = CDM_ST_DONE;
      end
      default: begin
        next_state = CDM_ST_IDLE;
        next_done = 1'b1;
        next_rdata = sfr_q ? sfr_rd : ram.rdata;
        next_rbit = next_rdata[pos_q];
        if (sfr_q && op_q == CDM_OP_WRITE) begin
          if (bit_q) begin
            next_wdata_q = merged;
          end
          if (byte_q == CDM_ADDR_STACK_POINTER) begin
            next_stack_pointer = bit_q ? merged : wdata_q;
          end else if (byte_q == CDM_ADDR_DATA_POINTER_LOW) begin
            next_data_pointer_low = bit_q ? merged : wdata_q;
          end else if (byte_q == CDM_ADDR_DATA_POINTER_HIGH) begin
            next_data_pointer_high = bit_q ? merged : wdata_q;
          end else if (byte_q == CDM_ADDR_PROGRAM_STATUS_WORD) begin
            next_program_status_word = bit_q ? merged : wdata_q;
          end else if (byte_q == CDM_ADDR_ACCUMULATOR) begin
            next_accumulator = bit_q ? merged : wdata_q;
          end else if (byte_q == CDM_ADDR_MULTIPLY_AUX) begin
            next_multiply_aux_register = bit_q ? merged : wdata_q;
          end else begin
            next_ext_req = 1'b1;
            next_ext_write = 1'b1;
            next_ext_addr = byte_q;
            next_ext_wdata = bit_q ? merged : wdata_q;
          end
        end
        // bit access only on 0x0/0x8 registers
        if (sfr_q && bit_q && (byte_q[2:0] & CDM_SFR_BIT_NIBBLE_MASK) != 3'h0) begin
          next_bad_bit = 1'b1;
        end
      end
    endcase
  end

  // ---------------------------------------------
  // Registers
  // ---------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state <= CDM_ST_IDLE;
      stack_pointer <= CDM_RST_STACK_POINTER;
      data_pointer_low <= CDM_RST_OTHER;
      data_pointer_high <= CDM_RST_OTHER;
      program_status_word <= CDM_RST_OTHER;
      accumulator <= CDM_RST_OTHER;
      multiply_aux_register <= CDM_RST_OTHER;
      rdata <= CDM_RST_OTHER;
      rbit <= 1'b0;
      done <= 1'b0;
      bad_bit <= 1'b0;
      ext_req <= 1'b0;
      ext_write <= 1'b0;
      ext_addr <= CDM_RST_OTHER;
      ext_wdata <= CDM_RST_OTHER;
      op_q <= CDM_OP_NONE;
      bit_q <= 1'b0;
      wbit_q <= 1'b0;
      sfr_q <= 1'b0;
      byte_q <= CDM_RST_OTHER;
      wdata_q <= CDM_RST_OTHER;
      pos_q <= 3'h0;
    end else begin
      state <= next_state;
      stack_pointer <= next_stack_pointer;
      data_pointer_low <= next_data_pointer_low;
      data_pointer_high <= next_data_pointer_high;
      program_status_word <= next_program_status_word;
      accumulator <= next_accumulator;
      multiply_aux_register <= next_multiply_aux_register;
      rdata <= next_rdata;
      rbit <= next_rbit;
      done <= next_done;
      bad_bit <= next_bad_bit;
      ext_req <= next_ext_req;
      ext_write <= next_ext_write;
      ext_addr <= next_ext_addr;
      ext_wdata <= next_ext_wdata;
      op_q <= next_op_q;
      bit_q <= next_bit_q;
      wbit_q <= next_wbit_q;
      sfr_q <= next_sfr_q;
      byte_q <= next_byte_q;
      wdata_q <= next_wdata_q;
      pos_q <= next_pos_q;
    end
  end
endmodule : cdm_core_map
`default_nettype wire

/* test/cdm_core_map_assertions.sv */
// Purpose: Port checker for cdm_core_map.
// Assumes: Requests only while idle.
// Notes: Busy is rebuilt here from req and done.
`default_nettype none
module cdm_core_map_assertions
  import cdm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic req,
  input wire cdm_op_e op,
  input wire cdm_mode_e mode,
  input wire logic is_bit,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic done,
  input wire logic bad_bit,
  input wire logic [7:0] stack_pointer,
  input wire logic ext_req,
  input wire logic ext_write,
  input wire logic [7:0] ext_addr,
  input wire logic [7:0] ext_wdata
);
  // ------------------------------------------------
  // Helpers
  // ------------------------------------------------
  logic busy;
  logic acc;
  logic outside;
  assign acc = req && op != CDM_OP_NONE && !busy;
  // Direct byte access to a register kept outside
  assign outside = mode == CDM_MODE_DIRECT && !is_bit && addr[7] &&
    !(addr inside {8'h81, 8'h82, 8'h83, 8'hd0, 8'he0, 8'hf0});
  always_ff @(posedge sys_clk) begin
    if (reset) busy <= 1'b0;
    else if (done) busy <= 1'b0;
    else if (acc) busy <= 1'b1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // ------------------------------------------------
  // Properties
  // ------------------------------------------------
  a_reset_sp: assert property (disable iff (1'b0) reset |=> stack_pointer == 8'h07)
    else $error("stack pointer not 0x07 after reset");
  a_push_up: assert property (acc && op == CDM_OP_PUSH |=> stack_pointer == $past(stack_pointer) + 8'h01)
    else $error("push did not raise stack pointer");
  a_pop_down: assert property (acc && op == CDM_OP_POP |=> stack_pointer == $past(stack_pointer) - 8'h01)
    else $error("pop did not lower stack pointer");
  a_done_two: assert property (acc && mode != CDM_MODE_INDIRECT |=> !done ##1 done)
    else $error("direct access not done in two cycles");
  a_done_three: assert property (acc && mode == CDM_MODE_INDIRECT |=> !done [*2] ##1 done)
    else $error("indirect access not done in three cycles");
  a_ext_read: assert property (acc && outside && op == CDM_OP_READ |=> ext_req && !ext_write && ext_addr == $past(addr))
    else $error("outside read not routed");
  a_ext_write: assert property (acc && outside && op == CDM_OP_WRITE |-> ##2 ext_req && ext_write && done &&
    ext_wdata == $past(wdata, 2))
    else $error("outside write not routed");
  a_indir_inside: assert property (acc && mode != CDM_MODE_DIRECT |=> !ext_req [*3])
    else $error("indirect access left the memory");
  a_bit_ok: assert property (done |-> !bad_bit)
    else $error("valid bit access flagged");
  c_push: cover property (acc && op == CDM_OP_PUSH);
  c_pop: cover property (acc && op == CDM_OP_POP);
  c_indir: cover property (acc && mode == CDM_MODE_INDIRECT);
  c_ext: cover property (ext_req && ext_write);
endmodule : cdm_core_map_assertions
bind cdm_core_map cdm_core_map_assertions cdm_core_map_assertions_inst (.sys_clk(sys_clk), .reset(reset),
  .req(req), .op(op), .mode(mode), .is_bit(is_bit), .addr(addr), .wdata(wdata), .done(done), .bad_bit(bad_bit),
  .stack_pointer(stack_pointer), .ext_req(ext_req), .ext_write(ext_write), .ext_addr(ext_addr),
  .ext_wdata(ext_wdata));
`default_nettype wire

/* test/cdm_ext_model.sv */
// Purpose: Outside special registers on the ext port.
// Assumes: Answer shows as soon as ext_addr stands, held to next request.
// Notes: Preset contents differ from the address so stale reads show.
`default_nettype none
module cdm_ext_model (
  input wire logic sys_clk,
  input wire logic ext_req,
  input wire logic ext_write,
  input wire logic [7:0] ext_addr,
  input wire logic [7:0] ext_wdata,
  output logic [7:0] ext_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [256];
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
  end
  always @(posedge sys_clk) begin
    if (ext_req && ext_write) mem[ext_addr] <= ext_wdata;
  end
  // Map takes read data in the cycle its registered ext_req stands
  assign ext_rdata = mem[ext_addr];
endmodule : cdm_ext_model
`default_nettype wire

/* test/cdm_core_map_tb.sv */
// Purpose: Self-checking bench for cdm_core_map.
// Assumes: Qualifiers held until done, req one cycle.
// Notes: Outside registers come from cdm_ext_model.
`default_nettype none
module cdm_core_map_tb
  import cdm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, reset, req, is_bit, wbit, done, rbit, bad_bit, ext_req, ext_write, rb;
  cdm_op_e op;
  cdm_mode_e mode;
  logic [7:0] addr, wdata, rdata, stack_pointer, ext_addr, ext_wdata, ext_rdata, rd;
  logic [1:0] active_bank;
  int failures, total_checks, cycles;
  cdm_core_map cdm_core_map_inst (.sys_clk(sys_clk), .reset(reset), .req(req), .op(op), .mode(mode),
    .is_bit(is_bit), .addr(addr), .wdata(wdata), .wbit(wbit), .done(done), .rdata(rdata), .rbit(rbit),
    .bad_bit(bad_bit), .stack_pointer(stack_pointer), .active_bank(active_bank), .ext_req(ext_req),
    .ext_write(ext_write), .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata));
  cdm_ext_model cdm_ext_model_inst (.sys_clk(sys_clk), .ext_req(ext_req), .ext_write(ext_write),
    .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata));
  always #10 sys_clk = ~sys_clk;
  // Hang guard, run needs well under 1000 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic go(input cdm_op_e o, input cdm_mode_e m, input logic b, input logic [7:0] a,
    input logic [7:0] d, input logic w);
    int n;
    @(posedge sys_clk);
    #1;
    op = o;
    mode = m;
    is_bit = b;
    addr = a;
    wdata = d;
    wbit = w;
    req = 1'b1;
    @(posedge sys_clk);
    #1;
    req = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 6) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk("done", {7'h0, done}, 8'h01);
    rd = rdata;
    rb = rbit;
  endtask : go
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    go(CDM_OP_WRITE, CDM_MODE_DIRECT, 1'b0, a, d, 1'b0);
  endtask : wr
  task automatic rdx(input logic [7:0] a);
    go(CDM_OP_READ, CDM_MODE_DIRECT, 1'b0, a, 8'h00, 1'b0);
  endtask : rdx
  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  task automatic t_reset();
    chk("sp", stack_pointer, 8'h07);
    chk("bank", {6'h0, active_bank}, 8'h00);
    rdx(8'h81);
    chk("sp direct", rd, 8'h07);
  endtask : t_reset
  task automatic t_banks();
    for (int b = 0; b < 4; b++) begin
      wr(8'hd0, 8'(b << 3));
      chk("bank", {6'h0, active_bank}, 8'(b));
      go(CDM_OP_WRITE, CDM_MODE_WORKING, 1'b0, 8'h07, 8'(8'h40 + b), 1'b0);
    end
    for (int b = 0; b < 4; b++) begin
      rdx(8'(b * 8 + 7));
      chk("bank reg", rd, 8'(8'h40 + b));
    end
    wr(8'hd0, 8'h00);
  endtask : t_banks
  task automatic t_stack();
    go(CDM_OP_PUSH, CDM_MODE_DIRECT, 1'b0, 8'h00, 8'h11, 1'b0);
    chk("sp push", stack_pointer, 8'h08);
    rdx(8'h08);
    chk("pushed", rd, 8'h11);
    go(CDM_OP_POP, CDM_MODE_DIRECT, 1'b0, 8'h00, 8'h00, 1'b0);
    chk("popped", rd, 8'h11);
    chk("sp pop", stack_pointer, 8'h07);
    // stack pointer set to 0xFF so the next push wraps into bank 0
    wr(8'h81, 8'hff);
    go(CDM_OP_PUSH, CDM_MODE_DIRECT, 1'b0, 8'h00, 8'h33, 1'b0);
    chk("sp wrap", stack_pointer, 8'h00);
    rdx(8'h00);
    chk("wrap byte", rd, 8'h33);
    go(CDM_OP_POP, CDM_MODE_DIRECT, 1'b0, 8'h00, 8'h00, 1'b0);
    chk("sp back", stack_pointer, 8'hff);
  endtask : t_stack
  task automatic t_indirect();
    wr(8'h00, 8'h89);
    wr(8'h01, 8'h30);
    go(CDM_OP_WRITE, CDM_MODE_INDIRECT, 1'b0, 8'h00, 8'h5a, 1'b0);
    go(CDM_OP_WRITE, CDM_MODE_INDIRECT, 1'b0, 8'h01, 8'ha5, 1'b0);
    go(CDM_OP_READ, CDM_MODE_INDIRECT, 1'b0, 8'h00, 8'h00, 1'b0);
    chk("upper ram", rd, 8'h5a);
    rdx(8'h30);
    chk("via r1", rd, 8'ha5);
    rdx(8'h89);
    chk("sfr 89", rd, 8'h89 ^ 8'h5a);
    wr(8'h99, 8'h3c);
    rdx(8'h99);
    chk("sfr 99", rd, 8'h3c);
    go(CDM_OP_WRITE, CDM_MODE_DIRECT, 1'b1, 8'h9b, 8'h00, 1'b1);
    rdx(8'h98);
    chk("sfr ext bit", rd, 8'hca);
  endtask : t_indirect
  task automatic t_bits();
    wr(8'h22, 8'h00);
    go(CDM_OP_WRITE, CDM_MODE_DIRECT, 1'b1, 8'h13, 8'h00, 1'b1);
    rdx(8'h22);
    chk("bit 13", rd, 8'h08);
    wr(8'h2f, 8'h80);
    go(CDM_OP_READ, CDM_MODE_DIRECT, 1'b1, 8'h7f, 8'h00, 1'b0);
    chk("bit 7f", {7'h0, rb}, 8'h01);
    go(CDM_OP_READ, CDM_MODE_DIRECT, 1'b1, 8'h7e, 8'h00, 1'b0);
    chk("bit 7e", {7'h0, rb}, 8'h00);
    wr(8'he0, 8'h00);
    go(CDM_OP_WRITE, CDM_MODE_DIRECT, 1'b1, 8'he5, 8'h00, 1'b1);
    rdx(8'he0);
    chk("sfr bit", rd, 8'h20);
  endtask : t_bits
  initial begin
    sys_clk = 1'b0;
    reset = 1'b1;
    {req, is_bit, wbit} = 3'h0;
    addr = 8'h00;
    wdata = 8'h00;
    op = CDM_OP_NONE;
    mode = CDM_MODE_DIRECT;
    {failures, total_checks, cycles} = {32'h0, 32'h0, 32'h0};
    repeat (5) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    t_reset();
    t_banks();
    t_stack();
    t_indirect();
    t_bits();
    @(posedge sys_clk);
    #1;
    reset = 1'b1;
    @(posedge sys_clk);
    #1;
    reset = 1'b0;
    t_reset();
    close_out();
  end
endmodule : cdm_core_map_tb
`default_nettype wire
